// >>> hdl/rx_seq_pkg.sv
// Package: constants, types and timing for the receive mode sequencer
package rx_seq_pkg;

  localparam int unsigned MCLK_HZ = 20_000_000;
  localparam int unsigned PUP_ALWAYS_US = 2700;
  localparam int unsigned PUP_DUTY_US = 8200;
  localparam int unsigned TUNE_US = 300;
  localparam int unsigned PUP_ALWAYS_CYC = (PUP_ALWAYS_US * 20);
  localparam int unsigned PUP_DUTY_CYC = (PUP_DUTY_US * 20);
  localparam int unsigned TUNE_CYC = (TUNE_US * (MCLK_HZ / 1_000_000));
  localparam int unsigned SLEEP_MIN_MS = 3;
  localparam int unsigned SLEEP_MAX_MS = 134_152_192;
  localparam int unsigned RX_MIN_TICK = 1;
  localparam int unsigned LP_PERIOD_CYC = 20_000;
  localparam int unsigned LP_TOL_CYC = 200;
  localparam int unsigned RECAL_TICKS = 1024;

  localparam logic [2:0] PRE_DEF = 3'h1;
  localparam logic [2:0] PRE_MIN = 3'h1;
  localparam logic [2:0] PRE_MAX = 3'h4;
  localparam logic [6:0] DIV_MIN = 7'h02;
  localparam logic [6:0] DIV_MAX = 7'h40;
  localparam logic [8:0] BW_MIN_KHZ = 9'h032;
  localparam logic [8:0] BW_MAX_KHZ = 9'h14A;
  localparam logic [8:0] BW_AUTO_DEF = 9'h0C8;
  localparam logic [7:0] SQ_OFFSET_DEF = 8'h28;
  localparam logic [7:0] RSSI_FULL = 8'hFF;

  typedef enum logic [1:0] {
    GPO_RX_ACTIVE = 2'b00,
    GPO_SYS_CLK   = 2'b01,
    GPO_DATA_CLK  = 2'b10,
    GPO_LOW_BAT   = 2'b11
  } gpo_sel_t;

  typedef enum logic [2:0] {
    ST_POWER_UP = 3'b000,
    ST_CAL      = 3'b001,
    ST_TUNE     = 3'b010,
    ST_RX       = 3'b011,
    ST_SLEEP    = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic       dutyCycle;
    logic [2:0] preambleBytes;
    logic       clkOutEn;
    logic [6:0] clkDiv;
    gpo_sel_t   gpoSel;
    logic       gpoInvert;
    logic       bwAuto;
    logic [8:0] bwKhz;
    logic       squelchEn;
    logic [7:0] squelchOffset;
  } cfg_t;

  typedef struct packed {
    logic       bit_;
    logic [7:0] rssi;
  } rx_word_t;

endpackage

// >>> hdl/skid_buffer.sv
// Two-entry valid/ready buffer for demodulated samples
`timescale 1ns/1ps
`default_nettype none
module skid_buffer
  import rx_seq_pkg::*;
#(
  parameter int WIDTH = 9
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  logic [WIDTH-1:0] mem_r [2];
  logic             wrPtr_r;
  logic             rdPtr_r;
  logic [1:0]       count_r;
  logic             doWr;
  logic             doRd;

  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (doWr) begin
        wrPtr_r <= ~wrPtr_r;
      end
      if (doRd) begin
        rdPtr_r <= ~rdPtr_r;
      end
      case ({doWr, doRd})
        2'b10: begin
          count_r <= count_r + 2'h1;
          inReady <= (count_r == 2'h0);
          outValid <= 1'b1;
        end
        2'b01: begin
          count_r <= count_r - 2'h1;
          inReady <= 1'b1;
          outValid <= (count_r == 2'h2);
        end
        default: begin
          count_r <= count_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (doWr) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outData <= '0;
    end else begin
      outData <= mem_r[doRd ? ~rdPtr_r : rdPtr_r];
      if (doWr && ((count_r == 2'h0) || (doRd && count_r == 2'h1))) begin
        outData <= inData;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/rx_operating_mode_sequencer.sv
// Top: power-up, tune, receive and sleep sequencing of the OOK receiver
// How it works
// - Preamble length one to four, default one
// - Clock output divides crystal by 2..64
// - Output selects rx-active, clock, data clock, battery
// - Optional inversion of the general output
// - Bandwidth 50..330 kHz or automatic
// - Auto squelch sets threshold above noise
// - Signal strength digitised to eight bits
// - Sleep timer runs on low-power ticks
// - Low-power oscillator calibrated, then periodically
// - Power-up lasts 2.7 or 8.2 ms
// - Always-receive keeps oscillator and timer off
// - Tuning takes about 300 us
// - Sleep powers all but timer, never always-receive
// - Receive outputs data, timed in duty mode
// - Always-receive stays in receive forever
// - Duty mode cycles tune, receive, sleep
// - Duty mode clock output only tune/receive
// - Stored setting picks mode after power-up
// - Mode choices duty or always, default always
// - Receive time configurable in duty mode
`timescale 1ns/1ps
`default_nettype none
module rx_operating_mode_sequencer
  import rx_seq_pkg::*;
#(
  parameter int unsigned PUP_A_CYC  = PUP_ALWAYS_CYC,
  parameter int unsigned PUP_D_CYC  = PUP_DUTY_CYC,
  parameter int unsigned LP_CAL_CYC = LP_PERIOD_CYC,
  parameter int unsigned SLEEP_W    = 28,
  parameter int unsigned RX_W       = 27
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire cfg_t               cfg,
  input  wire logic [SLEEP_W-1:0] sleepMs,
  input  wire logic [RX_W-1:0]    rxTicks,
  input  wire logic               lpTick,
  input  wire logic [7:0]         rssiLevel,
  input  wire logic               lowBattery,
  input  wire logic               dataClock,
  input  wire logic               hostReady,
  output logic                    dataOut,
  output logic                    dataValid,
  output logic [7:0]              rssiOut,
  output logic                    sysClockOutPin,
  output logic                    generalPurposeOutput,
  output logic                    rxActive,
  output logic                    lpOscEn,
  output logic                    blocksPowered,
  output logic                    lpCalDone,
  output logic [7:0]              lpTrim,
  output logic [7:0]              squelchLevel,
  output logic [2:0]              preambleLen,
  output logic [8:0]              bwSel
);

  // ------------------------------------------------------------
  // Configuration capture
  // ------------------------------------------------------------
  logic modeDuty_r;
  seq_state_t state_r;
  logic [31:0] cnt_r;
  logic [SLEEP_W-1:0] sleepCnt_r;
  logic [RX_W-1:0] rxCnt_r;

  // Strap-like mode caught after reset release, then held
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      modeDuty_r <= 1'b0;
    end else if (state_r == ST_POWER_UP && cnt_r == 32'h0) begin
      modeDuty_r <= cfg.dutyCycle;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      preambleLen <= PRE_DEF;
      bwSel <= BW_AUTO_DEF;
    end else begin
      if (cfg.preambleBytes < PRE_MIN) begin
        preambleLen <= PRE_DEF;
      end else if (cfg.preambleBytes > PRE_MAX) begin
        preambleLen <= PRE_MAX;
      end else begin
        preambleLen <= cfg.preambleBytes;
      end
      if (cfg.bwAuto) begin
        bwSel <= BW_AUTO_DEF;
      end else if (cfg.bwKhz < BW_MIN_KHZ) begin
        bwSel <= BW_MIN_KHZ;
      end else if (cfg.bwKhz > BW_MAX_KHZ) begin
        bwSel <= BW_MAX_KHZ;
      end else begin
        bwSel <= cfg.bwKhz;
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  logic calOk;
  logic [SLEEP_W-1:0] sleepLoad;
  assign sleepLoad = (sleepMs < SLEEP_W'(SLEEP_MIN_MS)) ?
                     SLEEP_W'(SLEEP_MIN_MS) : sleepMs;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_POWER_UP;
      cnt_r <= 32'h0;
      sleepCnt_r <= '0;
      rxCnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      case (state_r)
        ST_POWER_UP: begin
          if (cnt_r + 32'h1 >= (modeDuty_r ? PUP_D_CYC : PUP_A_CYC)) begin
            cnt_r <= 32'h0;
            state_r <= modeDuty_r ? ST_CAL : ST_TUNE;
          end
        end
        ST_CAL: begin
          if (calOk) begin
            cnt_r <= 32'h0;
            state_r <= ST_TUNE;
          end
        end
        ST_TUNE: begin
          if (cnt_r + 32'h1 >= TUNE_CYC) begin
            cnt_r <= 32'h0;
            state_r <= ST_RX;
            rxCnt_r <= (rxTicks == '0) ? RX_W'(RX_MIN_TICK) : rxTicks;
          end
        end
        ST_RX: begin
          if (modeDuty_r && lpTick) begin
            rxCnt_r <= rxCnt_r - RX_W'(1);
            if (rxCnt_r == RX_W'(1)) begin
              state_r <= ST_SLEEP;
              sleepCnt_r <= sleepLoad;
            end
          end
          // Always-receive never leaves here
          if (!modeDuty_r) begin
            state_r <= ST_RX;
          end
        end
        ST_SLEEP: begin
          if (lpTick) begin
            sleepCnt_r <= sleepCnt_r - SLEEP_W'(1);
            if (sleepCnt_r == SLEEP_W'(1)) begin
              cnt_r <= 32'h0;
              state_r <= ST_TUNE;
            end
          end
        end
        default: begin
          state_r <= ST_POWER_UP;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Low-power oscillator calibration
  // ------------------------------------------------------------
  // Measure mclk cycles per tick; nudge trim toward nominal period
  logic [31:0] lpMeas_r;
  logic [10:0] recal_r;
  logic measure;
  assign measure = lpOscEn && (state_r == ST_CAL || recal_r == 11'h0);
  assign calOk = lpCalDone;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lpMeas_r <= 32'h0;
      lpTrim <= 8'h80;
      lpCalDone <= 1'b0;
      recal_r <= 11'h0;
    end else begin
      lpMeas_r <= lpMeas_r + 32'h1;
      if (lpTick) begin
        lpMeas_r <= 32'h0;
        if (lpCalDone && recal_r != 11'h0) begin
          recal_r <= recal_r - 11'h1;
        end
        if (measure && lpMeas_r != 32'h0) begin
          if (lpMeas_r > LP_CAL_CYC + LP_TOL_CYC) begin
            lpTrim <= lpTrim + 8'h1;
          end else if (lpMeas_r + LP_TOL_CYC < LP_CAL_CYC) begin
            lpTrim <= lpTrim - 8'h1;
          end else begin
            lpCalDone <= 1'b1;
            recal_r <= 11'(RECAL_TICKS);
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Power and clock output
  // ------------------------------------------------------------
  logic [6:0] divCnt_r;
  logic [6:0] divSel;
  logic divClk_r;
  logic clkGate;
  assign divSel = (cfg.clkDiv < DIV_MIN) ? DIV_MIN :
                  (cfg.clkDiv > DIV_MAX) ? DIV_MAX : cfg.clkDiv;
  assign clkGate = cfg.clkOutEn && (!modeDuty_r ||
                   state_r == ST_TUNE || state_r == ST_RX);

  // Divider runs on mclk standing in for the crystal
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCnt_r <= 7'h0;
      divClk_r <= 1'b0;
    end else if (divCnt_r + 7'h1 >= divSel) begin
      divCnt_r <= 7'h0;
      divClk_r <= ~divClk_r;
    end else begin
      divCnt_r <= divCnt_r + 7'h1;
      if (divCnt_r + 7'h1 == (divSel >> 1)) begin
        divClk_r <= ~divClk_r;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sysClockOutPin <= 1'b0;
      lpOscEn <= 1'b0;
      blocksPowered <= 1'b1;
      rxActive <= 1'b0;
    end else begin
      sysClockOutPin <= clkGate & divClk_r;
      lpOscEn <= modeDuty_r && state_r != ST_POWER_UP;
      blocksPowered <= !(modeDuty_r && state_r == ST_SLEEP);
      rxActive <= (state_r == ST_RX);
    end
  end

  logic gpoRaw;
  always_comb begin
    case (cfg.gpoSel)
      GPO_RX_ACTIVE: gpoRaw = rxActive;
      GPO_SYS_CLK:   gpoRaw = sysClockOutPin;
      GPO_DATA_CLK:  gpoRaw = dataClock;
      GPO_LOW_BAT:   gpoRaw = lowBattery;
      default:       gpoRaw = rxActive;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      generalPurposeOutput <= 1'b0;
    end else begin
      generalPurposeOutput <= gpoRaw ^ cfg.gpoInvert;
    end
  end

  // ------------------------------------------------------------
  // Signal strength, squelch and demodulation
  // ------------------------------------------------------------
  logic [7:0] noise_r;
  logic [8:0] sqSum;
  assign sqSum = {1'b0, noise_r} + {1'b0, cfg.squelchOffset};

  // Slow-rising, fast-falling floor tracker
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      noise_r <= 8'h0;
      squelchLevel <= SQ_OFFSET_DEF;
      rssiOut <= 8'h0;
    end else begin
      rssiOut <= rssiLevel;
      if (state_r == ST_RX) begin
        if (rssiLevel < noise_r) begin
          noise_r <= rssiLevel;
        end else if (lpTick && rssiLevel > noise_r) begin
          noise_r <= noise_r + 8'h1;
        end
      end
      if (cfg.squelchEn) begin
        squelchLevel <= sqSum[8] ? RSSI_FULL : sqSum[7:0];
      end else begin
        squelchLevel <= cfg.squelchOffset;
      end
    end
  end

  rx_word_t word;
  rx_word_t bufOut;
  logic bufValid;
  logic bufReady;
  assign word.bit_ = (rssiOut > squelchLevel);
  assign word.rssi = rssiOut;

  skid_buffer #(
    .WIDTH($bits(rx_word_t))
  ) u_buf (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (state_r == ST_RX),
    .inReady  (bufReady),
    .inData   (word),
    .outValid (bufValid),
    .outReady (hostReady),
    .outData  (bufOut)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dataOut <= 1'b0;
      dataValid <= 1'b0;
    end else begin
      dataOut <= bufValid ? bufOut.bit_ : 1'b0;
      // Strobe: one pulse per word the host took on this edge
      dataValid <= bufValid && hostReady;
    end
  end

endmodule
`default_nettype wire

// >>> dv/rx_seq_props.sv
// Assertion checker for the receive mode sequencer
`timescale 1ns/1ps
`default_nettype none
module rx_seq_props
  import rx_seq_pkg::*;
#(
  parameter int unsigned SLEEP_W = 28
) (
  input wire logic               mclk,
  input wire logic               rst,
  input wire cfg_t               cfg,
  input wire logic [SLEEP_W-1:0] sleepMs,
  input wire logic               lpTick,
  input wire logic [7:0]         rssiLevel,
  input wire logic [7:0]         rssiOut,
  input wire logic               sysClockOutPin,
  input wire logic               generalPurposeOutput,
  input wire logic               rxActive,
  input wire logic               lpOscEn,
  input wire logic               blocksPowered,
  input wire logic [2:0]         preambleLen,
  input wire logic [8:0]         bwSel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [15:0]        tuneCnt_r;
  logic [SLEEP_W-1:0] slpTicks_r;
  logic               slept_r;
  // ----
  // Helpers
  // ----
  // Tune measured only after a sleep; power-up would inflate it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) tuneCnt_r <= '0;
    else if (!blocksPowered || rxActive) tuneCnt_r <= '0;
    else tuneCnt_r <= tuneCnt_r + 16'h1;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) slpTicks_r <= '0;
    else if (blocksPowered) slpTicks_r <= '0;
    else if (lpTick) slpTicks_r <= slpTicks_r + 1'b1;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) slept_r <= 1'b0;
    else if (!blocksPowered) slept_r <= 1'b1;
  end
  // ----
  // Properties
  // ----
  a_sleep_never_always: assert property (
    !cfg.dutyCycle |-> blocksPowered) else $error("sleep in always mode");
  a_low_power_oscillator_off_always: assert property (
    !cfg.dutyCycle |-> !lpOscEn) else $error("oscillator on in always mode");
  a_preamble_range: assert property (
    preambleLen inside {[3'h1:3'h4]}) else $error("preamble out of range");
  a_bw_range: assert property (
    bwSel inside {[9'h032:9'h14A]}) else $error("bandwidth out of range");
  a_gpo_rx_level: assert property (
    (cfg.gpoSel == GPO_RX_ACTIVE && $stable(cfg) && $stable(rxActive))[*2]
    |-> generalPurposeOutput == (rxActive ^ cfg.gpoInvert))
    else $error("general output not receive level");
  a_clk_disabled: assert property (
    (!cfg.clkOutEn)[*3] |-> !sysClockOutPin) else $error("clock while off");
  a_clk_sleep_off: assert property (
    (cfg.dutyCycle && !blocksPowered)[*2] |-> !sysClockOutPin)
    else $error("clock output during sleep");
  a_rssi_delay: assert property (
    !$past(rst) |-> rssiOut == $past(rssiLevel)) else $error("rssi late");
  a_rx_stays: assert property (
    !cfg.dutyCycle && rxActive |=> rxActive) else $error("left receive");
  a_tune_time: assert property (
    $rose(rxActive) && slept_r |-> tuneCnt_r inside {[16'h176B:16'h1775]})
    else $error("tune length wrong");
  a_sleep_time: assert property (
    $rose(blocksPowered) && slept_r |-> slpTicks_r + 1'b1 >= sleepMs
    && slpTicks_r <= sleepMs + 1'b1) else $error("sleep length wrong");
endmodule

bind rx_operating_mode_sequencer rx_seq_props #(.SLEEP_W(SLEEP_W))
  rx_seq_props_inst (.mclk(mclk), .rst(rst), .cfg(cfg),
  .sleepMs(sleepMs), .lpTick(lpTick), .rssiLevel(rssiLevel),
  .rssiOut(rssiOut), .sysClockOutPin(sysClockOutPin),
  .generalPurposeOutput(generalPurposeOutput), .rxActive(rxActive),
  .lpOscEn(lpOscEn), .blocksPowered(blocksPowered),
  .preambleLen(preambleLen), .bwSel(bwSel));
`default_nettype wire

// >>> dv/host_model.sv
// Host side model: drains demodulated words, stalls on request
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       stall,
  input  wire logic       dataValid,
  output var logic        hostReady,
  output var logic [15:0] wordCount
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) hostReady <= 1'b0;
    else hostReady <= !stall;
  end
  // Strobe already marks a completed hand-over
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) wordCount <= '0;
    else if (dataValid) wordCount <= wordCount + 16'h1;
  end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the receive mode sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rx_seq_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  cfg_t        cfg = '0;
  logic [27:0] sleepMs = 28'h0000003;
  logic [26:0] rxTicks = 27'h0000002;
  logic        lpTick = 1'b0;
  logic [7:0]  rssiLevel = 8'h00;
  logic        lowBattery = 1'b1;
  logic        dataClock = 1'b1;
  logic        stall = 1'b0;
  logic        hostReady, dataOut, dataValid, sysClockOutPin, general_purpose_output;
  logic        rxActive, lpOscEn, blocksPowered, lpCalDone;
  logic [7:0]  lpTrim, squelchLevel;
  logic [2:0]  preambleLen;
  logic [8:0]  bwSel;
  logic [15:0] wordCount;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          lpDiv = 0;

  rx_operating_mode_sequencer #(.PUP_A_CYC(50), .PUP_D_CYC(100),
    .LP_CAL_CYC(40)) rx_operating_mode_sequencer_inst (
    .mclk(mclk), .rst(rst), .cfg(cfg), .sleepMs(sleepMs),
    .rxTicks(rxTicks), .lpTick(lpTick), .rssiLevel(rssiLevel),
    .lowBattery(lowBattery), .dataClock(dataClock), .hostReady(hostReady),
    .dataOut(dataOut), .dataValid(dataValid), .rssiOut(),
    .sysClockOutPin(sysClockOutPin), .generalPurposeOutput(general_purpose_output),
    .rxActive(rxActive), .lpOscEn(lpOscEn), .blocksPowered(blocksPowered),
    .lpCalDone(lpCalDone), .lpTrim(lpTrim), .squelchLevel(squelchLevel),
    .preambleLen(preambleLen), .bwSel(bwSel));
  host_model host_model_inst (.mclk(mclk), .rst(rst), .stall(stall),
    .dataValid(dataValid), .hostReady(hostReady), .wordCount(wordCount));

  always #25 mclk = ~mclk;
  // Low-power tick every 40 cycles, matching the shortened calibration
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    lpDiv <= (lpDiv == 39) ? 0 : lpDiv + 1;
    lpTick <= (lpDiv == 39);
    rssiLevel <= rssiLevel + 8'h07;
    if (cycles == 40000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic do_reset(input logic duty);
    rst <= 1'b1;
    cfg.dutyCycle <= duty;
    tick(16);
    check("pwr_rst", blocksPowered, 1'b1);
    check("trim_rst", lpTrim, 8'h80);
    check("squelch_rst", squelchLevel, 8'h28);
    check("pre_rst", preambleLen, 3'h1);
    check("bw_rst", bwSel, 9'h0C8);
    rst <= 1'b0;
  endtask
  task automatic wait_rx(input logic v, output int n);
    n = 0;
    while (rxActive !== v && n < 20000) begin
      tick(1);
      n++;
    end
  endtask

  task automatic t_always();
    int n;
    int r;
    logic p;
    do_reset(1'b0);
    wait_rx(1'b1, n);
    check("pup_tune", n >= 6040 && n <= 6065, 1'b1);
    tick(500);
    check("rx_hold", rxActive, 1'b1);
    check("osc_off", lpOscEn, 1'b0);
    check("words", wordCount > 16'h0, 1'b1);
    for (int s = 0; s < 8; s++) begin
      cfg.gpoSel <= gpo_sel_t'(s[1:0]);
      cfg.gpoInvert <= s[2];
      tick(4);
      check("gpo", general_purpose_output, (s[1:0] != 2'h1) ^ s[2]);
    end
    cfg.gpoSel <= GPO_LOW_BAT;
    cfg.gpoInvert <= 1'b0;
    lowBattery <= 1'b0;
    tick(4);
    check("gpo_bat", general_purpose_output, 1'b0);
    cfg.clkOutEn <= 1'b1;
    for (int d = 2; d <= 64; d = d * 32) begin
      cfg.clkDiv <= 7'(d);
      tick(8);
      r = 0;
      repeat (256) begin
        p = sysClockOutPin;
        tick(1);
        r += int'(!p && sysClockOutPin === 1'b1);
      end
      check("clk_rises", r >= 256 / d - 1 && r <= 256 / d + 1, 1'b1);
    end
    cfg.preambleBytes <= 3'h7;
    cfg.bwAuto <= 1'b0;
    cfg.bwKhz <= 9'h1FF;
    tick(3);
    check("pre_hi", preambleLen, 3'h4);
    check("bw_hi", bwSel, 9'h14A);
    cfg.preambleBytes <= 3'h3;
    cfg.bwKhz <= 9'h010;
    tick(3);
    check("pre_mid", preambleLen, 3'h3);
    check("bw_lo", bwSel, 9'h032);
    cfg.bwAuto <= 1'b1;
    tick(3);
    check("bw_auto", bwSel, 9'h0C8);
    cfg.squelchOffset <= 8'h30;
    tick(3);
    check("sq_fixed", squelchLevel, 8'h30);
    cfg.squelchEn <= 1'b1;
    tick(3);
    check("sq_auto", squelchLevel >= 8'h30 && squelchLevel <= 8'h40, 1'b1);
  endtask

  task automatic t_duty();
    int n;
    int k;
    logic [15:0] w;
    do_reset(1'b1);
    cfg.clkDiv <= 7'h02;
    wait_rx(1'b1, n);
    check("duty_pup", n > 6100 && n < 20000, 1'b1);
    check("osc_on", lpOscEn, 1'b1);
    check("cal_done", lpCalDone, 1'b1);
    stall <= 1'b1;
    wait_rx(1'b0, n);
    check("rx_time", n >= 38 && n <= 95, 1'b1);
    tick(3);
    check("sleep_pwr", blocksPowered, 1'b0);
    w = wordCount;
    k = 3;
    while (blocksPowered === 1'b0 && k < 400) begin
      check("sleep_clk", sysClockOutPin, 1'b0);
      tick(1);
      k++;
    end
    check("sleep_len", k >= 78 && k <= 130, 1'b1);
    stall <= 1'b0;
    tick(6);
    check("drained", wordCount - w, 16'h2);
    wait_rx(1'b1, n);
    check("retune", n >= 5990 && n <= 6010, 1'b1);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    cfg.preambleBytes = 3'h1;
    cfg.bwAuto = 1'b1;
    cfg.bwKhz = 9'h0C8;
    cfg.squelchOffset = 8'h28;
    t_always();
    cfg.clkOutEn <= 1'b1;
    t_duty();
    end_of_test();
  end
endmodule
`default_nettype wire
